// ==== design/iopu_pkg.sv ====
// Package for the port-access instruction unit: opcodes, widths, reset values
package iopu_pkg;
  localparam int NIB_W = 4;
  localparam int TWO_W = 2;
  localparam int DPORT_W = 4;
  localparam int YIDX_W = 2;
  localparam logic [NIB_W-1:0] ZERO_NIB = 4'h0;
  localparam logic [NIB_W-1:0] ONES_NIB = 4'hF;
  localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
  localparam logic [DPORT_W-1:0] RST_DPORT = 4'h0;
  localparam logic [TWO_W-1:0] RST_TWO = 2'h0;
  localparam logic RST_BIT = 1'b0;

  typedef enum logic [4:0] {
    IOPU_NOP, IOPU_IN_NIBA, IOPU_OUT_NIBA, IOPU_IN_NIBB, IOPU_OUT_NIBB,
    IOPU_IN_TWO, IOPU_OUT_TWO, IOPU_SET_DALL, IOPU_CLR_DBIT, IOPU_SET_DBIT,
    IOPU_TST_DBIT, IOPU_SET_C, IOPU_CLR_C, IOPU_TST_C, IOPU_IN_K,
    IOPU_OUT_K, IOPU_WR_WKA, IOPU_RD_WKA, IOPU_WR_WKB, IOPU_RD_WKB,
    IOPU_WR_WKC, IOPU_RD_WKC, IOPU_WR_PUA, IOPU_WR_PUB, IOPU_WR_PUC
  } iopu_op_e;
endpackage

// ==== design/iopu_top.sv ====
// Port-access instruction execution unit of a 4-bit microcomputer
// Summary of operation
// - First nibble port input loads accumulator
// - Accumulator drives first nibble port latch
// - Second nibble port input loads accumulator
// - Accumulator copied to second nibble latch
// - Two-bit port goes into accumulator low bits
// - Accumulator low two bits drive two-bit port
// - Clear bit-addressed port bit chosen by index
// - Set bit-addressed port bit chosen by index
// - Skip next when indexed bit is zero
// - Flag port set and clear instructions hold
// - Skip next when flag port is one
// - Key port level into accumulator bit zero
// - Accumulator bit zero drives key port
// - Accumulator written to first wakeup register
// - First wakeup register read to accumulator
// - Accumulator written to second wakeup register
// - Second wakeup register read to accumulator
// - Accumulator written to third wakeup register
// - Third wakeup register read to accumulator
// - Accumulator stored to first pull-up register
// - Accumulator stored to second pull-up register
// - Accumulator stored to third pull-up register
`timescale 1ns/1ps
module iopu_top
  import iopu_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Core instruction side
  input  wire logic                       op_valid,
  input  wire iopu_pkg::iopu_op_e         op_code,
  input  wire logic [iopu_pkg::NIB_W-1:0] acc_in,
  input  wire logic [iopu_pkg::YIDX_W-1:0] bit_index,
  output logic                            acc_load,
  output logic [iopu_pkg::NIB_W-1:0]      acc_out,
  output logic                            skip_next,
  // Port pins
  input  wire logic [iopu_pkg::NIB_W-1:0] nibble_io_port_first_in,
  input  wire logic [iopu_pkg::NIB_W-1:0] nibble_io_port_second_in,
  input  wire logic [iopu_pkg::TWO_W-1:0] two_bit_io_port_in,
  input  wire logic                       key_port_in,
  output logic [iopu_pkg::NIB_W-1:0]      nibble_io_port_first_out,
  output logic [iopu_pkg::NIB_W-1:0]      nibble_io_port_second_out,
  output logic [iopu_pkg::TWO_W-1:0]      two_bit_io_port_out,
  output logic [iopu_pkg::DPORT_W-1:0]    bit_port_out,
  output logic                            flag_port_out,
  output logic                            key_port_out,
  // Control registers
  output logic [iopu_pkg::NIB_W-1:0]      wakeup_control_first,
  output logic [iopu_pkg::NIB_W-1:0]      wakeup_control_second,
  output logic [iopu_pkg::NIB_W-1:0]      wakeup_control_third,
  output logic [iopu_pkg::NIB_W-1:0]      pullup_control_first,
  output logic [iopu_pkg::NIB_W-1:0]      pullup_control_second,
  output logic [iopu_pkg::NIB_W-1:0]      pullup_control_third
);
  import iopu_pkg::*;

  typedef struct packed {
    logic [2:0][NIB_W-1:0] s0;
    logic [2:0][NIB_W-1:0] s1;
    logic [TWO_W-1:0]      s3a;
    logic [TWO_W-1:0]      s3b;
    logic [TWO_W-1:0]      s3c;
    logic [2:0]            sk;
  } iopu_sync_s;

  typedef struct packed {
    iopu_sync_s         sy;
    logic               acc_load;
    logic [NIB_W-1:0]   acc_out;
    logic               skip_next;
    logic [NIB_W-1:0]   nib1;
    logic [NIB_W-1:0]   nib2;
    logic [TWO_W-1:0]   two;
    logic [DPORT_W-1:0] d;
    logic               c;
    logic               k;
    logic [NIB_W-1:0]   wk1;
    logic [NIB_W-1:0]   wk2;
    logic [NIB_W-1:0]   wk3;
    logic [NIB_W-1:0]   pul1;
    logic [NIB_W-1:0]   pul2;
    logic [NIB_W-1:0]   pul3;
    logic [NIB_W-1:0]   nib1_f;
    logic [NIB_W-1:0]   nib2_f;
    logic [TWO_W-1:0]   two_f;
    logic               k_f;
  } iopu_state_s;

  iopu_state_s st_q;
  iopu_state_s st_d;

  // Pins pass three stages; a filtered level updates only once stages two and three agree
  // Agreement rejects a one-cycle glitch at the price of one more cycle before a read sees it
  always_comb begin
    st_d = st_q;
    st_d.acc_load = 1'b0;
    st_d.skip_next = 1'b0;
    st_d.sy.s0[0] = st_q.sy.s0[1];
    st_d.sy.s0[1] = st_q.sy.s0[2];
    st_d.sy.s0[2] = nibble_io_port_first_in;
    st_d.sy.s1[0] = st_q.sy.s1[1];
    st_d.sy.s1[1] = st_q.sy.s1[2];
    st_d.sy.s1[2] = nibble_io_port_second_in;
    st_d.sy.s3a = two_bit_io_port_in;
    st_d.sy.s3b = st_q.sy.s3a;
    st_d.sy.s3c = st_q.sy.s3b;
    st_d.sy.sk = {key_port_in, st_q.sy.sk[2:1]};
    if (st_q.sy.s0[1] == st_q.sy.s0[0]) begin
      st_d.nib1_f = st_q.sy.s0[0];
    end
    if (st_q.sy.s1[1] == st_q.sy.s1[0]) begin
      st_d.nib2_f = st_q.sy.s1[0];
    end
    if (st_q.sy.s3b == st_q.sy.s3c) begin
      st_d.two_f = st_q.sy.s3c;
    end
    if (st_q.sy.sk[1] == st_q.sy.sk[0]) begin
      st_d.k_f = st_q.sy.sk[0];
    end
    if (op_valid) begin
      unique case (op_code)
        IOPU_IN_NIBA: begin
          st_d.acc_load = 1'b1;
          st_d.acc_out = st_q.nib1_f;
        end
        IOPU_OUT_NIBA: st_d.nib1 = acc_in;
        IOPU_IN_NIBB: begin
          st_d.acc_load = 1'b1;
          st_d.acc_out = st_q.nib2_f;
        end
        IOPU_OUT_NIBB: st_d.nib2 = acc_in;
        IOPU_IN_TWO: begin
          st_d.acc_load = 1'b1;
          st_d.acc_out = {{(NIB_W-TWO_W){1'b0}}, st_q.two_f};
        end
        IOPU_OUT_TWO: st_d.two = acc_in[TWO_W-1:0];
        IOPU_SET_DALL: st_d.d = ONES_NIB;
        IOPU_CLR_DBIT: st_d.d[bit_index] = 1'b0;
        IOPU_SET_DBIT: st_d.d[bit_index] = 1'b1;
        IOPU_TST_DBIT: st_d.skip_next = ~st_q.d[bit_index];
        IOPU_SET_C: st_d.c = 1'b1;
        IOPU_CLR_C: st_d.c = 1'b0;
        IOPU_TST_C: st_d.skip_next = st_q.c;
        IOPU_IN_K: begin
          st_d.acc_load = 1'b1;
          st_d.acc_out = {{(NIB_W-1){1'b0}}, st_q.k_f};
        end
        IOPU_OUT_K: st_d.k = acc_in[0];
        IOPU_WR_WKA: st_d.wk1 = acc_in;
        IOPU_RD_WKA: begin
          st_d.acc_load = 1'b1;
          st_d.acc_out = st_q.wk1;
        end
        IOPU_WR_WKB: st_d.wk2 = acc_in;
        IOPU_RD_WKB: begin
          st_d.acc_load = 1'b1;
          st_d.acc_out = st_q.wk2;
        end
        IOPU_WR_WKC: st_d.wk3 = acc_in;
        IOPU_RD_WKC: begin
          st_d.acc_load = 1'b1;
          st_d.acc_out = st_q.wk3;
        end
        IOPU_WR_PUA: st_d.pul1 = acc_in;
        IOPU_WR_PUB: st_d.pul2 = acc_in;
        IOPU_WR_PUC: st_d.pul3 = acc_in;
        // No-op and unlisted codes leave every latch untouched
        default: st_d.acc_load = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign acc_load = st_q.acc_load;
  assign acc_out = st_q.acc_out;
  assign skip_next = st_q.skip_next;
  assign nibble_io_port_first_out = st_q.nib1;
  assign nibble_io_port_second_out = st_q.nib2;
  assign two_bit_io_port_out = st_q.two;
  assign bit_port_out = st_q.d;
  assign flag_port_out = st_q.c;
  assign key_port_out = st_q.k;
  assign wakeup_control_first = st_q.wk1;
  assign wakeup_control_second = st_q.wk2;
  assign wakeup_control_third = st_q.wk3;
  assign pullup_control_first = st_q.pul1;
  assign pullup_control_second = st_q.pul2;
  assign pullup_control_third = st_q.pul3;

  // A wakeup round trip is a write step followed at once by a read step
  sequence s_wr_wk1;
    op_valid && op_code == IOPU_WR_WKA;
  endsequence

  sequence s_rd_wk1;
    op_valid && op_code == IOPU_RD_WKA;
  endsequence

  property p_in_nib1;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_IN_NIBA |=> acc_load && acc_out == $past(st_q.nib1_f);
  endproperty
  a_in_nib1: assert property (p_in_nib1) else $error("first nibble read wrong");

  property p_out_nib1;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_OUT_NIBA |=> nibble_io_port_first_out == $past(acc_in);
  endproperty
  a_out_nib1: assert property (p_out_nib1) else $error("first nibble write wrong");

  property p_in_nib2;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_IN_NIBB |=> acc_load && acc_out == $past(st_q.nib2_f);
  endproperty
  a_in_nib2: assert property (p_in_nib2) else $error("second nibble read wrong");

  property p_out_nib2;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_OUT_NIBB |=> nibble_io_port_second_out == $past(acc_in);
  endproperty
  a_out_nib2: assert property (p_out_nib2) else $error("second nibble write wrong");

  property p_in_two_low;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_IN_TWO |=> acc_out[TWO_W-1:0] == $past(st_q.two_f);
  endproperty
  a_in_two_low: assert property (p_in_two_low) else $error("two-bit read low bits wrong");

  property p_in_two;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_IN_TWO |=> acc_out[NIB_W-1:TWO_W] == '0 && acc_load;
  endproperty
  a_in_two: assert property (p_in_two) else $error("two-bit read high bits set");

  property p_out_two;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_OUT_TWO |=> two_bit_io_port_out == $past(acc_in[TWO_W-1:0]);
  endproperty
  a_out_two: assert property (p_out_two) else $error("two-bit write wrong");

  property p_clr_d;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_CLR_DBIT |=> bit_port_out[$past(bit_index)] == 1'b0;
  endproperty
  a_clr_d: assert property (p_clr_d) else $error("indexed bit not cleared");

  property p_set_d;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_SET_DBIT |=> bit_port_out[$past(bit_index)] == 1'b1;
  endproperty
  a_set_d: assert property (p_set_d) else $error("indexed bit not set");

  property p_tst_d;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_TST_DBIT |=> skip_next == !$past(st_q.d[bit_index]);
  endproperty
  a_tst_d: assert property (p_tst_d) else $error("bit test skip wrong");

  property p_set_c;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_SET_C |=> flag_port_out;
  endproperty
  a_set_c: assert property (p_set_c) else $error("flag port not set");

  property p_clr_c;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_CLR_C |=> !flag_port_out;
  endproperty
  a_clr_c: assert property (p_clr_c) else $error("flag port not cleared");

  property p_tst_c;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_TST_C |=> skip_next == $past(flag_port_out);
  endproperty
  a_tst_c: assert property (p_tst_c) else $error("flag test skip wrong");

  property p_in_key;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_IN_K |=> acc_load && acc_out[0] == $past(st_q.k_f) && acc_out[NIB_W-1:1] == '0;
  endproperty
  a_in_key: assert property (p_in_key) else $error("key read wrong");

  property p_out_key;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_OUT_K |=> key_port_out == $past(acc_in[0]);
  endproperty
  a_out_key: assert property (p_out_key) else $error("key write wrong");

  property p_wr_wk1;
    @(posedge clk) disable iff (!resetn)
      s_wr_wk1 |=> wakeup_control_first == $past(acc_in);
  endproperty
  a_wr_wk1: assert property (p_wr_wk1) else $error("first wakeup write wrong");

  property p_wk1_round;
    @(posedge clk) disable iff (!resetn)
      s_wr_wk1 ##1 s_rd_wk1 |=> acc_out == $past(acc_in, 2);
  endproperty
  a_wk1_round: assert property (p_wk1_round) else $error("wakeup read-back wrong");

  property p_wr_wk2;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_WR_WKB |=> wakeup_control_second == $past(acc_in);
  endproperty
  a_wr_wk2: assert property (p_wr_wk2) else $error("second wakeup write wrong");

  property p_rd_wk2;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_RD_WKB |=> acc_load && acc_out == $past(wakeup_control_second);
  endproperty
  a_rd_wk2: assert property (p_rd_wk2) else $error("second wakeup read wrong");

  property p_wr_wk3;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_WR_WKC |=> wakeup_control_third == $past(acc_in);
  endproperty
  a_wr_wk3: assert property (p_wr_wk3) else $error("third wakeup write wrong");

  property p_rd_wk3;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_RD_WKC |=> acc_load && acc_out == $past(wakeup_control_third);
  endproperty
  a_rd_wk3: assert property (p_rd_wk3) else $error("third wakeup read wrong");

  property p_wr_pul1;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_WR_PUA |=> pullup_control_first == $past(acc_in);
  endproperty
  a_wr_pul1: assert property (p_wr_pul1) else $error("first pull-up write wrong");

  property p_wr_pul2;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_WR_PUB |=> pullup_control_second == $past(acc_in);
  endproperty
  a_wr_pul2: assert property (p_wr_pul2) else $error("second pull-up write wrong");

  property p_wr_pul3;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_WR_PUC |=> pullup_control_third == $past(acc_in);
  endproperty
  a_wr_pul3: assert property (p_wr_pul3) else $error("third pull-up write wrong");

  property p_set_all;
    @(posedge clk) disable iff (!resetn)
      op_valid && op_code == IOPU_SET_DALL |=> bit_port_out == ONES_NIB;
  endproperty
  a_set_all: assert property (p_set_all) else $error("port-wide set failed");
endmodule

// ==== verif/iopu_pin_model.sv ====
// Pin-side model: drives the port input pins just after each clock edge
`timescale 1ns/1ps
module iopu_pin_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Requested pin levels
  input  wire logic [10:0] level_req,
  // Pins toward the unit
  output logic [3:0]       nib_a,
  output logic [3:0]       nib_b,
  output logic [1:0]       pair,
  output logic             key
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) {key, pair, nib_b, nib_a} <= 11'h000;
    else {key, pair, nib_b, nib_a} <= level_req;
  end
endmodule

// ==== verif/iopu_top_tb_top.sv ====
// Self-checking bench for the port-access instruction unit
`timescale 1ns/1ps
module iopu_top_tb_top;
  import iopu_pkg::*;
  logic clk = 0, resetn = 0, op_valid = 0;
  iopu_op_e op_code = IOPU_NOP;
  logic [3:0] acc_in = 4'h0, acc_out, n1o, n2o, bpo, nib_a, nib_b;
  logic [3:0] ku [3], pl [3], e_ku [3], e_pl [3];
  logic [1:0] bit_index = 2'h0, two_o, pair, e_two;
  logic acc_load, skip_next, flag_o, key_o, key, e_c, e_k;
  logic [10:0] pv = 11'h000;
  logic [3:0] e_acc, e_n1, e_n2, e_d;
  int seed = 5, n_fail = 0, checks_done = 0, r, i, j;
  iopu_pin_model iopu_pin_model_inst (.clk(clk), .resetn(resetn), .level_req(pv),
    .nib_a(nib_a), .nib_b(nib_b), .pair(pair), .key(key));
  iopu_top iopu_top_inst (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
    .acc_in(acc_in), .bit_index(bit_index), .acc_load(acc_load), .acc_out(acc_out),
    .skip_next(skip_next), .nibble_io_port_first_in(nib_a), .nibble_io_port_second_in(nib_b),
    .two_bit_io_port_in(pair), .key_port_in(key), .nibble_io_port_first_out(n1o),
    .nibble_io_port_second_out(n2o), .two_bit_io_port_out(two_o), .bit_port_out(bpo),
    .flag_port_out(flag_o), .key_port_out(key_o), .wakeup_control_first(ku[0]),
    .wakeup_control_second(ku[1]), .wakeup_control_third(ku[2]), .pullup_control_first(pl[0]),
    .pullup_control_second(pl[1]), .pullup_control_third(pl[2]));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_state(input logic ld, input logic sk);
    chk({3'h0, acc_load}, {3'h0, ld}, "load");
    chk({3'h0, skip_next}, {3'h0, sk}, "skip");
    chk(acc_out, e_acc, "acc");
    chk(n1o, e_n1, "n1");
    chk(n2o, e_n2, "n2");
    chk({2'h0, two_o}, {2'h0, e_two}, "two");
    chk(bpo, e_d, "dport");
    chk({2'h0, flag_o, key_o}, {2'h0, e_c, e_k}, "flag key");
    for (j = 0; j < 3; j++) chk(ku[j], e_ku[j], "wake");
    for (j = 0; j < 3; j++) chk(pl[j], e_pl[j], "pull");
  endtask
  // Expected accumulator value for each read-type code
  function automatic logic [3:0] read_exp(input iopu_op_e c);
    case (c)
      IOPU_IN_NIBA: return pv[3:0];
      IOPU_IN_NIBB: return pv[7:4];
      IOPU_IN_TWO: return {2'h0, pv[9:8]};
      IOPU_IN_K: return {3'h0, pv[10]};
      IOPU_RD_WKA: return e_ku[0];
      IOPU_RD_WKB: return e_ku[1];
      IOPU_RD_WKC: return e_ku[2];
      default: return e_acc;
    endcase
  endfunction
  task automatic run_op(input iopu_op_e c, input logic [3:0] a, input logic [1:0] y);
    logic ld, sk;
    ld = 0;
    sk = 0;
    op_valid = 1;
    op_code = c;
    acc_in = a;
    bit_index = y;
    case (c)
      IOPU_IN_NIBA, IOPU_IN_NIBB, IOPU_IN_TWO, IOPU_IN_K, IOPU_RD_WKA, IOPU_RD_WKB, IOPU_RD_WKC: begin
        ld = 1;
        e_acc = read_exp(c);
      end
      IOPU_OUT_NIBA: e_n1 = a;
      IOPU_OUT_NIBB: e_n2 = a;
      IOPU_OUT_TWO: e_two = a[1:0];
      IOPU_OUT_K: e_k = a[0];
      IOPU_SET_DALL: e_d = 4'hF;
      IOPU_CLR_DBIT: e_d[y] = 1'b0;
      IOPU_SET_DBIT: e_d[y] = 1'b1;
      IOPU_TST_DBIT: sk = ~e_d[y];
      IOPU_SET_C: e_c = 1'b1;
      IOPU_CLR_C: e_c = 1'b0;
      IOPU_TST_C: sk = e_c;
      IOPU_WR_WKA, IOPU_WR_WKB, IOPU_WR_WKC: e_ku[(c - IOPU_WR_WKA) / 2] = a;
      IOPU_WR_PUA, IOPU_WR_PUB, IOPU_WR_PUC: e_pl[c - IOPU_WR_PUA] = a;
      default: ;
    endcase
    @(posedge clk);
    #1;
    chk_state(ld, sk);
  endtask
  task automatic idle(input int n);
    op_valid = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      chk_state(1'b0, 1'b0);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {e_acc, e_n1, e_n2, e_d, e_two, e_c, e_k} = '0;
    for (j = 0; j < 3; j++) {e_ku[j], e_pl[j]} = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1;
    chk_state(1'b0, 1'b0);
    // Every code back to back, then each index through clear and test
    for (i = 0; i < 25; i++) run_op(iopu_op_e'(i), 4'hA ^ i[3:0], i[1:0]);
    for (i = 0; i < 4; i++) begin
      run_op(IOPU_SET_DALL, 4'h0, 2'h0);
      run_op(IOPU_CLR_DBIT, 4'h0, i[1:0]);
      run_op(IOPU_TST_DBIT, 4'h0, i[1:0]);
      run_op(IOPU_TST_DBIT, 4'h0, i[1:0] + 2'h1);
    end
    idle(1);
    $display("directed walk done");
    for (i = 0; i < 400; i++) begin
      if (i % 40 == 0) begin
        pv = 11'($random(seed));
        idle(8);
      end
      r = $random(seed);
      run_op(iopu_op_e'(5'(r[7:0] % 25)), r[11:8], r[13:12]);
    end
    idle(1);
    $display("random run done");
    // Asynchronous reset in mid-run must clear every latch and register
    resetn = 0;
    {e_acc, e_n1, e_n2, e_d, e_two, e_c, e_k} = '0;
    for (j = 0; j < 3; j++) {e_ku[j], e_pl[j]} = 8'h00;
    idle(2);
    resetn = 1;
    // Pins restart from the model's reset level, so the filter needs time to settle
    idle(8);
    run_op(IOPU_IN_NIBA, 4'h5, 2'h0);
    run_op(IOPU_WR_WKB, 4'h6, 2'h0);
    run_op(IOPU_RD_WKB, 4'h0, 2'h0);
    run_op(IOPU_IN_K, 4'h0, 2'h0);
    idle(1);
    $display("reset run done");
    give_verdict();
  end
  initial begin
    // About four times the roughly 540 cycles that the tests take
    #200000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
